// file: sim/stg_buzzer_model.sv
// piezo buzzer on the shared pin: counts driven edges, measures half period
// assumes the pin is sampled on the generator clock
`timescale 1ns/1ps
`default_nettype none

module stg_buzzer_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // pin as seen by the buzzer
    input  wire logic        pin_o,
    input  wire logic        pin_oe_n,
    // measured tone
    output logic      [12:0] half_len,
    output logic      [15:0] n_edges
);
    logic        last;
    logic [12:0] run;

    // a released pin does not move the membrane, so only driven edges count
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {last, run, half_len, n_edges} <= '0;
        end else if (!pin_oe_n && pin_o != last) begin
            last     <= pin_o;
            half_len <= run + 13'h0001;
            run      <= '0;
            n_edges  <= n_edges + 16'h0001;
        end else begin
            run <= run + 13'h0001;
        end
    end
endmodule
`default_nettype wire

// file: sim/stg_tone_gen_tb.sv
// self-checking bench of the tone generator with a buzzer on its pin
// assumes the design, its package and the checker are compiled before
`timescale 1ns/1ps
`default_nettype none

module stg_tone_gen_tb;
    logic        clk, rstn, reg_write, reg_read, port_data, port_oe_n;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic        pin_o, pin_oe_n, tone_out_pin;
    logic [12:0] half_len;
    logic [15:0] n_edges;
    int          fail_count = 0;
    int          n_compared = 0;

    stg_tone_gen dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .port_data(port_data), .port_oe_n(port_oe_n),
        .shared_port_pin_o(pin_o), .shared_port_pin_oe_n(pin_oe_n),
        .tone_out_pin(tone_out_pin));
    stg_buzzer_model buzzer (.clk(clk), .rstn(rstn), .pin_o(pin_o),
        .pin_oe_n(pin_oe_n), .half_len(half_len), .n_edges(n_edges));

    // 10 MHz clock
    always #50 clk = ~clk;

    task automatic close_out;
        if (fail_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, exp, mask);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        check("rdata", {8'h00, reg_rdata & mask}, {8'h00, exp});
    endtask

    // third driven edge after the write ends a full half period
    task automatic tone_chk(input logic [7:0] ctl, input logic [15:0] exp);
        int          t;
        logic [15:0] e0;
        wr(8'hf8, ctl);
        e0 = n_edges;
        t = 0;
        while (n_edges - e0 < 16'd3 && t < 20000) begin
            @(posedge clk);
            t++;
        end
        if (t == 20000) begin
            fail_count++;
            close_out();
        end
        check("half", {3'h0, half_len}, exp);
    endtask

    // a second write mid-tone clears the level and restarts the count
    task automatic s_restart;
        int n;
        wr(8'hf8, 8'h05);
        repeat (60) @(posedge clk);
        wr(8'hf8, 8'h05);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (!tone_out_pin && n < 300);
        check("restart", 16'(n), 16'd48);
    endtask

    // unrouted pin carries the port; routed pin is driven by the tone
    task automatic s_port;
        wr(8'hf9, 8'h00);
        port_oe_n <= 1'b0;
        port_data <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("pin", {14'h0, pin_o, pin_oe_n}, 16'h0002);
        wr(8'hf9, 8'h04);
        port_oe_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("routed", {14'h0, pin_o, pin_oe_n}, 16'h0000);
        @(posedge clk);
        port_data <= 1'b0;
    endtask

    // mid-run reset returns tone_out_pin, pin_oe_n and the control register to rest
    task automatic s_reset;
        @(posedge clk);
        rstn <= 1'b0;
        #1;
        check("rst", {14'h0, tone_out_pin, pin_oe_n}, 16'h0001);
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        rd(8'hf8, 8'h00, 8'hff);
    endtask

    initial begin
        {clk, rstn, reg_write, reg_read, port_data} = '0;
        {reg_addr, reg_wdata} = '0;
        port_oe_n = 1'b1;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        rd(8'hf8, 8'h00, 8'hff);
        rd(8'hf9, 8'h00, 8'hff);
        wr(8'hf8, 8'hc3);
        rd(8'hf8, 8'hc3, 8'hff);
        wr(8'hf9, 8'h5a);
        rd(8'hf9, 8'h5a, 8'hff);
        rd(8'hfb, 8'h00, 8'hff);
        s_port();
        for (int c = 0; c < 4; c++) begin
            tone_chk({2'(c), 6'h00}, 16'd8 << c);
        end
        tone_chk(8'h31, 16'd400);
        tone_chk(8'hff, 16'd4096);
        s_restart();
        rd(8'hfa, 8'h01, 8'hff);
        s_reset();
        close_out();
    end
endmodule
`default_nettype wire

// file: sim/stg_tone_props.sv
// port checker of the tone generator: register readback, tone timing, pin
// assumes one clock; shadows the two control registers from the writes
`timescale 1ns/1ps
`default_nettype none
`include "stg_params.svh"

module stg_tone_props #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              rstn,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_write,
    input wire logic              reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    // pins
    input wire logic              port_data,
    input wire logic              port_oe_n,
    input wire logic              shared_port_pin_o,
    input wire logic              shared_port_pin_oe_n,
    input wire logic              tone_out_pin
);
    logic [DATA_W-1:0] ctl, sel, next_ctl, next_sel;
    logic [12:0]       cnt, next_cnt, half;
    logic              armed, next_armed, wr_ctl, wr_sel;

    // decode of the two writes and the expected half period in clocks
    assign wr_ctl = reg_write && reg_addr == `STG_OFF_TONE_CONTROL;
    assign wr_sel = reg_write && reg_addr == `STG_OFF_PIN_FUNC_SELECT;
    assign half   = 13'(8 << ctl[7:6]) * 13'(ctl[5:0] + 1);

    // shadow registers; timing is only judged once a period was written
    always_comb begin
        next_ctl   = wr_ctl ? reg_wdata : ctl;
        next_sel   = wr_sel ? reg_wdata : sel;
        next_armed = armed | wr_ctl;
        next_cnt   = (wr_ctl || cnt == half) ? 13'h0001 : cnt + 13'h0001;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {ctl, sel, armed, cnt} <= '0;
        end else begin
            {ctl, sel, armed, cnt} <= {next_ctl, next_sel, next_armed,
                                       next_cnt};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    ctl_readback_a: assert property (reg_read && reg_addr == 8'hf8
        |=> reg_rdata == $past(ctl)) else $error("control readback");
    sel_readback_a: assert property (reg_read && reg_addr == 8'hf9
        |=> reg_rdata == $past(sel)) else $error("select readback");
    count_bound_a: assert property (reg_read && reg_addr == 8'hfa
        |=> reg_rdata[6:1] <= $past(ctl[5:0]) && !reg_rdata[7])
        else $error("counter above period");
    write_clear_a: assert property (wr_ctl |=> !tone_out_pin)
        else $error("level not cleared by write");
    toggle_match_a: assert property (armed && !wr_ctl && cnt == half
        |=> tone_out_pin != $past(tone_out_pin)) else $error("no toggle");
    hold_half_a: assert property (armed && !wr_ctl && cnt != half
        |=> $stable(tone_out_pin)) else $error("early toggle");
    pin_tone_a: assert property (sel[2] |=>
        shared_port_pin_o == $past(tone_out_pin) && !shared_port_pin_oe_n)
        else $error("pin not tone");
    pin_port_a: assert property (!sel[2] |=>
        shared_port_pin_o == $past(port_data)
        && shared_port_pin_oe_n == $past(port_oe_n)) else $error("pin not port");

    // main scenarios
    cov_slow: cover property (armed && ctl == 8'hff && cnt == half);
    cov_routed: cover property (sel[2] && tone_out_pin);
    cov_restart: cover property (wr_ctl && tone_out_pin);
endmodule

bind stg_tone_gen stg_tone_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .port_data(port_data), .port_oe_n(port_oe_n),
    .shared_port_pin_o(shared_port_pin_o),
    .shared_port_pin_oe_n(shared_port_pin_oe_n), .tone_out_pin(tone_out_pin));
`default_nettype wire

// file: src/stg_params.svh
// constants of the square wave tone generator: offsets, fields, resets
// assumes an 8-bit register port and a single 10 MHz clock
`ifndef STG_PARAMS_SVH
`define STG_PARAMS_SVH

// register port
`define STG_ADDR_W              8
`define STG_DATA_W              8
`define STG_OFF_TONE_CONTROL    8'hf8
`define STG_OFF_PIN_FUNC_SELECT 8'hf9
`define STG_OFF_TONE_STATUS     8'hfa

// tone_control fields
`define STG_PERIOD_MSB          5
`define STG_PERIOD_LSB          0
`define STG_PRESCALE_MSB        7
`define STG_PRESCALE_LSB        6

// pin_function_select field that routes the tone to the shared pin
`define STG_PIN_TONE_BIT        2

// tone_status fields
`define STG_STAT_LEVEL_BIT      0
`define STG_STAT_COUNT_LSB      1
`define STG_STAT_COUNT_MSB      6

// reset values
`define STG_RST_TONE_CONTROL    8'h00
`define STG_RST_PIN_FUNC_SELECT 8'h00

// timing: clock rate and the smallest prescaler ratio, as a power of two
`define STG_CLK_HZ              10000000
`define STG_PRESCALE_BASE_LOG2  3
`define STG_PRESCALE_CNT_W      6

`endif

// file: src/stg_pkg.sv
// types shared by the square wave tone generator files
// assumes the constants header is included by the modules that need it
package stg_pkg;

    // prescale select codes; each step doubles the divide ratio
    typedef enum logic [1:0] {
        STG_DIV_8  = 2'h0,
        STG_DIV_16 = 2'h1,
        STG_DIV_32 = 2'h2,
        STG_DIV_64 = 2'h3
    } stg_prescale_e;

    // six-bit period and counter value
    typedef logic [5:0] stg_period_t;

endpackage

// file: src/stg_prescaler.sv
// prescaler of the tone generator: one-cycle tick every 8, 16, 32 or 64 clocks
// assumes clear and select come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "stg_params.svh"

module stg_prescaler
    import stg_pkg::*;
#(
    parameter int CNT_W = `STG_PRESCALE_CNT_W
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // control
    input  wire stg_prescale_e prescale_select,
    input  wire logic          clear,
    // output
    output logic               tick
);

    logic [CNT_W-1:0] div_cnt;
    logic [CNT_W-1:0] next_div_cnt;
    logic [CNT_W-1:0] last_cnt;

    // terminal count is ratio minus one, ratio being 8 shifted by the code
    always_comb begin
        last_cnt = CNT_W'(((CNT_W+1)'(1) << (`STG_PRESCALE_BASE_LOG2 // RL10
                   + int'(prescale_select))) - (CNT_W+1)'(1));
        tick = (div_cnt == last_cnt) && !clear; // RL6
        next_div_cnt = div_cnt + CNT_W'(1);
        if (clear || tick) begin
            next_div_cnt = '0; // RL7
        end
    end

    // divider register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

endmodule
`default_nettype wire

// file: src/stg_tone_gen.sv
// square wave tone generator: registers, period counter, pin routing
// assumes a single-cycle register port on clk and port logic on clk
//
// Functional notes
// RL1 - six-bit counter, period register, prescale selector
// RL2 - fifty percent duty square wave output
// RL3 - pin carries tone only when select bit2
// RL4 - control bits five to zero hold period
// RL5 - frequency is clock over two, ratio, period+1
// RL6 - control bits seven, six pick prescale ratio
// RL7 - control write clears counter, restarts from zero
// RL8 - counter rises from zero to period value
// RL9 - prescale codes give ratios 8,16,32,64
// RL10 - period 3f with code 11 gives slowest tone
// RL11 - match toggles output and restarts counter
`timescale 1ns/1ps
`default_nettype none
`include "stg_params.svh"

module stg_tone_gen
    import stg_pkg::*;
#(
    parameter int ADDR_W = `STG_ADDR_W,
    parameter int DATA_W = `STG_DATA_W
) (
    // clock and asynchronous active-low reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [DATA_W-1:0] reg_rdata,
    // ordinary port function of the shared pin
    input  wire logic              port_data,
    input  wire logic              port_oe_n,
    // shared port pin
    output logic                   shared_port_pin_o,
    output logic                   shared_port_pin_oe_n,
    // raw tone level
    output logic                   tone_out_pin
);

    // reset release: asserted at once, released through two flops
    // a release close to an edge cannot split the flops across it
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // address decode, shared by the write and the read path
    // exact match only, so no register aliases over unused address bits
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] offset);
        addr_hit = (addr == offset);
    endfunction

    logic wr_control;
    logic wr_pin_func;

    // write strobes per register
    assign wr_control  = reg_write
                         && addr_hit(reg_addr, ADDR_W'(`STG_OFF_TONE_CONTROL));
    assign wr_pin_func = reg_write
                         && addr_hit(reg_addr,
                                     ADDR_W'(`STG_OFF_PIN_FUNC_SELECT));

    // software registers
    // plain storage; nothing in hardware writes them
    logic [DATA_W-1:0] tone_control;
    logic [DATA_W-1:0] next_tone_control;
    logic [DATA_W-1:0] pin_function_select;
    logic [DATA_W-1:0] next_pin_function_select;

    // register writes; all bits of both registers are kept and read back
    always_comb begin
        next_tone_control        = tone_control;
        next_pin_function_select = pin_function_select;
        if (wr_control) begin
            next_tone_control = reg_wdata;
        end
        if (wr_pin_func) begin
            next_pin_function_select = reg_wdata;
        end
    end

    // software register storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tone_control        <= `STG_RST_TONE_CONTROL;
            pin_function_select <= `STG_RST_PIN_FUNC_SELECT;
        end else begin
            tone_control        <= next_tone_control;
            pin_function_select <= next_pin_function_select;
        end
    end

    // field extraction
    // fields are wires into the stored bytes, no extra state
    stg_period_t   period_value;
    stg_prescale_e prescale_select;
    logic          tone_routed;

    assign period_value    =
        tone_control[`STG_PERIOD_MSB:`STG_PERIOD_LSB]; // RL4
    assign prescale_select = stg_prescale_e'(
        tone_control[`STG_PRESCALE_MSB:`STG_PRESCALE_LSB]);
    assign tone_routed     = pin_function_select[`STG_PIN_TONE_BIT];

    // prescaler: the fields already hold the new value one edge after a
    // write, and the divider is cleared by the same write, so the first
    // tick after a write comes a full ratio later under the new setting
    logic pre_tick;

    stg_prescaler #(
        .CNT_W           (`STG_PRESCALE_CNT_W)
    ) u_prescaler (
        .clk             (clk),
        .rst_n           (rst_n),
        .prescale_select (prescale_select), // RL9
        .clear           (wr_control),      // RL7
        .tick            (pre_tick)
    );

    // period counter and output toggle
    // half period = ratio * (period_value + 1) clocks, so the tone is
    // clk / (2 * ratio * (period_value + 1)) with equal high and low
    stg_period_t tone_count;
    stg_period_t next_tone_count;
    logic        tone_level;
    logic        next_tone_level;
    logic        period_match;

    // match against the live period value; a period lowered below the
    // count cannot strand the counter because writes clear it too
    assign period_match = (tone_count == period_value); // RL8

    always_comb begin
        next_tone_count = tone_count;
        next_tone_level = tone_level;
        if (wr_control) begin
            // restart from a known phase: counter and level both cleared
            next_tone_count = '0; // RL7
            next_tone_level = 1'b0;
        end else if (pre_tick) begin
            if (period_match) begin
                next_tone_count = '0;          // RL11
                next_tone_level = ~tone_level; // RL2
            end else begin
                next_tone_count = tone_count + stg_period_t'(1); // RL1
            end
        end
    end

    // counter and level storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tone_count <= '0;
            tone_level <= 1'b0;
        end else begin
            tone_count <= next_tone_count; // RL5
            tone_level <= next_tone_level;
        end
    end

    // slowest tone (code 11, period 3f) needs no wider counter: 6 bits
    // of period and 6 bits of prescale cover the whole range    // RL10

    assign tone_out_pin = tone_level;

    // shared pin routing: registered so the pin never glitches when the
    // select bit flips; costs one clock of latency on both functions
    logic next_pin_o;
    logic next_pin_oe_n;

    always_comb begin
        if (tone_routed) begin
            next_pin_o    = tone_level; // RL3
            next_pin_oe_n = 1'b0;
        end else begin
            next_pin_o    = port_data;
            next_pin_oe_n = port_oe_n;
        end
    end

    // pin drivers; released (not driven) during reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shared_port_pin_o    <= 1'b0;
            shared_port_pin_oe_n <= 1'b1;
        end else begin
            shared_port_pin_o    <= next_pin_o;
            shared_port_pin_oe_n <= next_pin_oe_n;
        end
    end

    // read path: data stand in the cycle after the strobe only
    // reads have no side effects, so software may poll status freely
    logic [DATA_W-1:0] read_mux;
    logic [DATA_W-1:0] next_rdata;
    logic [DATA_W-1:0] status_word;

    // live status: tone level and counter value, upper bit reads zero
    always_comb begin
        status_word = '0;
        status_word[`STG_STAT_LEVEL_BIT] = tone_level;
        status_word[`STG_STAT_COUNT_MSB:`STG_STAT_COUNT_LSB] = tone_count;
    end

    // unmapped addresses read as zero
    always_comb begin
        read_mux = '0;
        if (addr_hit(reg_addr, ADDR_W'(`STG_OFF_TONE_CONTROL))) begin
            read_mux = tone_control;
        end else if (addr_hit(reg_addr,
                              ADDR_W'(`STG_OFF_PIN_FUNC_SELECT))) begin
            read_mux = pin_function_select;
        end else if (addr_hit(reg_addr,
                              ADDR_W'(`STG_OFF_TONE_STATUS))) begin
            read_mux = status_word;
        end
        next_rdata = reg_read ? read_mux : '0;
    end

    // read data register; zero outside the answer cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule
`default_nettype wire
